// file: pkg/cwd_pkg.sv
package cwd_pkg;

  // ==========================================================
  // register map (word addresses as printed)
  localparam logic [15:0] OSC_WORD_ADDR   = 16'h8007;
  localparam logic [15:0] SUP_WORD_ADDR   = 16'h8008;
  localparam logic [15:0] WDT_WORD_ADDR   = 16'h8009;
  localparam logic [15:0] LOWV_WORD_ADDR  = 16'h8020;
  localparam logic [15:0] STATUS_ADDR     = 16'h8021;
  localparam logic [15:0] SW_CTRL_ADDR    = 16'h8022;

  // erased state of every word
  localparam logic [13:0] WORD_RESET      = 14'h3fff;

  // ==========================================================
  // field positions
  localparam int EXT_OSC_LSB     = 0;
  localparam int DEBUG_BIT       = 13;
  localparam int STACK_BIT       = 12;
  localparam int ONE_WAY_BIT     = 11;
  localparam int ZCROSS_DIS_BIT  = 10;
  localparam int BOR_LEVEL_BIT   = 9;
  localparam int BOR_MODE_LSB    = 6;
  localparam int LOWPWR_BOR_BIT  = 5;
  localparam int PUT_LSB         = 1;
  localparam int RST_PIN_BIT     = 0;
  localparam int WDT_CLK_LSB     = 11;
  localparam int WDT_WIN_LSB     = 8;

  // software control bits
  localparam int SW_ZCROSS_BIT   = 0;
  localparam int SW_BOR_BIT      = 1;
  localparam int SW_LOCK_BIT     = 2;
  localparam int SW_SLEEP_BIT    = 3;

  // ==========================================================
  // load sequence
  localparam logic [1:0] LOAD_WORDS = 2'h3;

  // power-up timer figures (ms) and counts at 25 MHz
  localparam int CLK_HZ          = 25_000_000;
  localparam int PUT_64_MS       = 64;
  localparam int PUT_16_MS       = 16;
  localparam int PUT_1_MS        = 1;
  localparam int PUT_64_CYC      = PUT_64_MS * (CLK_HZ / 1000);
  localparam int PUT_16_CYC      = PUT_16_MS * (CLK_HZ / 1000);
  localparam int PUT_1_CYC       = PUT_1_MS * (CLK_HZ / 1000);

  // ==========================================================
  typedef enum logic [2:0] {
    CWD_OSC_LOWPWR, CWD_OSC_MIDXTAL, CWD_OSC_FASTXTAL, CWD_OSC_RSVD,
    CWD_OSC_OFF, CWD_OSC_SLOW, CWD_OSC_MED, CWD_OSC_FAST
  } cwd_osc_mode_t;

  typedef enum logic [2:0] {
    CWD_WCLK_LFOSC, CWD_WCLK_DIVOSC, CWD_WCLK_SECOSC, CWD_WCLK_RSVD, CWD_WCLK_SW
  } cwd_wdt_clk_t;

  typedef enum logic [1:0] {
    CWD_PUT_1MS, CWD_PUT_16MS, CWD_PUT_64MS, CWD_PUT_OFF
  } cwd_put_t;

  typedef struct packed {
    cwd_osc_mode_t osc_mode;
    logic          fast_ext_clock;
    logic          medium_ext_clock;
    logic          slow_ext_clock;
    logic          high_speed_crystal;
    logic          mid_crystal;
    logic          low_power_crystal;
  } cwd_osc_ctl_t;

  typedef struct packed {
    logic         debug_en;
    logic         stack_fault_reset_en;
    logic         zero_cross_on;
    logic         brownout_active;
    logic         brownout_low_level;
    logic         low_power_brownout_en;
    logic         reset_pin_is_reset;
    logic         powerup_timer_en;
  } cwd_sup_ctl_t;

  typedef struct packed {
    cwd_wdt_clk_t clk_src;
    logic [2:0]   window_open_8ths;
    logic         window_sw_ctrl;
    logic         window_keyed;
  } cwd_wdt_ctl_t;

endpackage : cwd_pkg

// file: src/cwd_powerup_timer.sv
`timescale 1ns/1ps
// ==========================================================
// power-up delay counter
module cwd_put_timer #(
  parameter int unsigned DLY_64 = cwd_pkg::PUT_64_CYC,
  parameter int unsigned DLY_16 = cwd_pkg::PUT_16_CYC,
  parameter int unsigned DLY_1  = cwd_pkg::PUT_1_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              start,
  input  wire cwd_pkg::cwd_put_t sel,
  output logic                   done_ff
);
  logic [31:0] cnt_ff;
  logic        run_ff;
  logic [31:0] limit;

  always_comb begin
    case (sel)
      cwd_pkg::CWD_PUT_64MS: limit = DLY_64;
      cwd_pkg::CWD_PUT_16MS: limit = DLY_16;
      cwd_pkg::CWD_PUT_1MS:  limit = DLY_1;
      default:                limit = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= 32'h0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      cnt_ff  <= 32'h0;
      run_ff  <= (sel != cwd_pkg::CWD_PUT_OFF);
      done_ff <= (sel == cwd_pkg::CWD_PUT_OFF);
    end else if (run_ff) begin
      if (cnt_ff + 32'h1 >= limit) begin
        run_ff  <= 1'b0;
        done_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule : cwd_put_timer

// file: src/cwd_decoder.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - oscillator mode field decodes into three external clock and three crystal modes
// - supervisor bit 13 high disables background debugger, low enables it
// - bit 12 high lets stack faults reset the device
// - bit 11 high allows one clear/set of the pin-select lock only
// - bit 10 high: zero-cross off unless software enables it
// - bit 9 high picks lower brown-out trip level
// - brown-out mode: always, run-only, software, or disabled
// - any enabled brown-out uses the level from bit 9
// - bit 5 is active-low low-power brown-out enable
// - reset pin is reset when bit 0 high or low-voltage programming on
// - pin acting as reset, driven low, resets the device
// - watchdog clock select decodes software, reserved, secondary, divided, low-freq
// - window field gives opening percentage, software control and keyed access
// - low-voltage programming forces reset pin function, ignoring pin enable
module cwd_decoder (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic [15:0]           addr,
  input  wire logic [13:0]           wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic [13:0]                rdata_ff,
  input  wire logic [13:0]           nvm_data,
  output logic [15:0]                nvm_addr_ff,
  input  wire logic                  stack_fault,
  input  wire logic                  ext_reset_pin_n,
  input  wire logic                  in_sleep,
  output cwd_pkg::cwd_osc_ctl_t      osc_ctl_ff,
  output cwd_pkg::cwd_sup_ctl_t      sup_ctl_ff,
  output cwd_pkg::cwd_wdt_ctl_t      wdt_ctl_ff,
  output logic                       pin_select_locked_ff,
  output logic                       device_reset_ff,
  output logic                       config_ready_ff
);

  // ==========================================================
  // power-on load
  typedef enum logic [1:0] {CWD_LD_IDLE, CWD_LD_READ, CWD_LD_DONE} cwd_ld_state_t;

  cwd_ld_state_t state_ff;
  logic [1:0]    idx_ff;
  logic [13:0]   osc_word_ff;
  logic [13:0]   sup_word_ff;
  logic [13:0]   wdt_word_ff;
  logic [13:0]   lowv_word_ff;
  logic          put_start_ff;
  logic          put_done;
  logic [3:0]    sw_ctrl_ff;
  logic          lock_cycles_ff;
  logic          lock_freeze;
  logic          ext_reset_active;
  logic          low_voltage_prog_en;

  assign low_voltage_prog_en = lowv_word_ff[0];

  // nvm data arrives one cycle after its address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= CWD_LD_IDLE;
      idx_ff        <= 2'h0;
      nvm_addr_ff   <= cwd_pkg::OSC_WORD_ADDR;
      put_start_ff  <= 1'b0;
    end else begin
      put_start_ff  <= 1'b0;
      case (state_ff)
        CWD_LD_IDLE: begin
          state_ff    <= CWD_LD_READ;
          nvm_addr_ff <= nvm_addr_ff + 16'h1;
        end
        CWD_LD_READ: begin
          idx_ff <= idx_ff + 2'h1;
          if (idx_ff == cwd_pkg::LOAD_WORDS) begin
            state_ff      <= CWD_LD_DONE;
            put_start_ff  <= 1'b1;
          end else begin
            nvm_addr_ff <= (idx_ff == 2'h1) ? cwd_pkg::LOWV_WORD_ADDR : nvm_addr_ff + 16'h1;
          end
        end
        CWD_LD_DONE: state_ff <= CWD_LD_DONE;
        default:     state_ff <= CWD_LD_IDLE;
      endcase
    end
  end

  // words written only during load; no later write path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_word_ff <= cwd_pkg::WORD_RESET;
      sup_word_ff <= cwd_pkg::WORD_RESET;
      wdt_word_ff <= cwd_pkg::WORD_RESET;
      lowv_word_ff <= cwd_pkg::WORD_RESET;
    end else if (state_ff == CWD_LD_READ) begin
      case (idx_ff)
        2'h0:    osc_word_ff <= nvm_data;
        2'h1:    sup_word_ff <= nvm_data;
        2'h2:    wdt_word_ff <= nvm_data;
        default: lowv_word_ff <= {13'h0, nvm_data[13]};
      endcase
    end
  end

  // ==========================================================
  // power-up timer
  cwd_put_timer u_put (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (put_start_ff),
    .sel     (cwd_pkg::cwd_put_t'(sup_word_ff[cwd_pkg::PUT_LSB +: 2])),
    .done_ff (put_done)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) config_ready_ff <= 1'b0;
    else       config_ready_ff <= put_done && (state_ff == CWD_LD_DONE);
  end

  // ==========================================================
  // oscillator decode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_ctl_ff <= '0;
    end else begin
      osc_ctl_ff.osc_mode <= cwd_pkg::cwd_osc_mode_t'(osc_word_ff[2:0]);
      osc_ctl_ff.fast_ext_clock     <= osc_word_ff[2:0] == 3'h7;
      osc_ctl_ff.medium_ext_clock   <= osc_word_ff[2:0] == 3'h6;
      osc_ctl_ff.slow_ext_clock     <= osc_word_ff[2:0] == 3'h5;
      osc_ctl_ff.high_speed_crystal <= osc_word_ff[2:0] == 3'h2;
      osc_ctl_ff.mid_crystal        <= osc_word_ff[2:0] == 3'h1;
      osc_ctl_ff.low_power_crystal  <= osc_word_ff[2:0] == 3'h0;
    end
  end

  // ==========================================================
  // supervisor decode
  logic [1:0] bor_mode;
  logic       bor_on;
  assign bor_mode = sup_word_ff[cwd_pkg::BOR_MODE_LSB +: 2];

  always_comb begin
    case (bor_mode)
      2'h3:    bor_on = 1'b1;
      2'h2:    bor_on = !in_sleep;
      2'h1:    bor_on = sw_ctrl_ff[cwd_pkg::SW_BOR_BIT];
      default: bor_on = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sup_ctl_ff <= '0;
    end else begin
      sup_ctl_ff.debug_en             <= !sup_word_ff[cwd_pkg::DEBUG_BIT];
      sup_ctl_ff.stack_fault_reset_en <= sup_word_ff[cwd_pkg::STACK_BIT];
      // software enable only matters when the fuse disables it
      sup_ctl_ff.zero_cross_on <= !sup_word_ff[cwd_pkg::ZCROSS_DIS_BIT]
                                  || sw_ctrl_ff[cwd_pkg::SW_ZCROSS_BIT];
      sup_ctl_ff.brownout_active    <= bor_on;
      sup_ctl_ff.brownout_low_level <= sup_word_ff[cwd_pkg::BOR_LEVEL_BIT];
      sup_ctl_ff.low_power_brownout_en <= !sup_word_ff[cwd_pkg::LOWPWR_BOR_BIT];
      sup_ctl_ff.reset_pin_is_reset <= low_voltage_prog_en
                                       || sup_word_ff[cwd_pkg::RST_PIN_BIT];
      sup_ctl_ff.powerup_timer_en   <= sup_word_ff[cwd_pkg::PUT_LSB +: 2] != 2'h3;
    end
  end

  // ==========================================================
  // pin-select lock
  // one-way: after the first set of the lock, the lock bit is frozen; other control bits still take writes
  assign lock_freeze = sup_word_ff[cwd_pkg::ONE_WAY_BIT] && lock_cycles_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_select_locked_ff <= 1'b0;
      lock_cycles_ff       <= 1'b0;
    end else if (wr_stb && addr == cwd_pkg::SW_CTRL_ADDR && !lock_freeze) begin
      pin_select_locked_ff <= wdata[cwd_pkg::SW_LOCK_BIT];
      if (wdata[cwd_pkg::SW_LOCK_BIT] && !pin_select_locked_ff)
        lock_cycles_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      sw_ctrl_ff <= 4'h0;
    else if (wr_stb && addr == cwd_pkg::SW_CTRL_ADDR)
      sw_ctrl_ff <= wdata[3:0];
  end

  // ==========================================================
  // reset requests
  assign ext_reset_active = sup_ctl_ff.reset_pin_is_reset && !ext_reset_pin_n;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      device_reset_ff <= 1'b0;
    else
      device_reset_ff <= ext_reset_active
                         || (stack_fault && sup_ctl_ff.stack_fault_reset_en);
  end

  // ==========================================================
  // watchdog decode
  logic [2:0] wclk;
  logic [2:0] wwin;
  assign wclk = wdt_word_ff[cwd_pkg::WDT_CLK_LSB +: 3];
  assign wwin = wdt_word_ff[cwd_pkg::WDT_WIN_LSB +: 3];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdt_ctl_ff <= '0;
    end else begin
      case (wclk)
        3'h7:    wdt_ctl_ff.clk_src <= cwd_pkg::CWD_WCLK_SW;
        3'h2:    wdt_ctl_ff.clk_src <= cwd_pkg::CWD_WCLK_SECOSC;
        3'h1:    wdt_ctl_ff.clk_src <= cwd_pkg::CWD_WCLK_DIVOSC;
        3'h0:    wdt_ctl_ff.clk_src <= cwd_pkg::CWD_WCLK_LFOSC;
        default: wdt_ctl_ff.clk_src <= cwd_pkg::CWD_WCLK_RSVD;
      endcase
      // opening in eighths minus one: 7 means 100 percent
      wdt_ctl_ff.window_open_8ths <= (wwin == 3'h6) ? 3'h7 : wwin;
      wdt_ctl_ff.window_sw_ctrl   <= wwin == 3'h7;
      wdt_ctl_ff.window_keyed     <= wwin <= 3'h3;
    end
  end

  // ==========================================================
  // register reads, one cycle later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 14'h0;
    end else if (rd_stb) begin
      case (addr)
        cwd_pkg::OSC_WORD_ADDR: rdata_ff <= osc_word_ff;
        cwd_pkg::SUP_WORD_ADDR: rdata_ff <= sup_word_ff;
        cwd_pkg::WDT_WORD_ADDR: rdata_ff <= wdt_word_ff;
        cwd_pkg::LOWV_WORD_ADDR: rdata_ff <= lowv_word_ff;
        cwd_pkg::STATUS_ADDR:   rdata_ff <= {11'h0, config_ready_ff,
                                             pin_select_locked_ff, lock_cycles_ff};
        cwd_pkg::SW_CTRL_ADDR:  rdata_ff <= {10'h0, sw_ctrl_ff};
        default:                rdata_ff <= 14'h0;
      endcase
    end else begin
      rdata_ff <= 14'h0;
    end
  end

  // ==========================================================
  // checks
  a_debug_polarity: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> sup_ctl_ff.debug_en == !$past(sup_word_ff[13]))
    else $error("debugger enable does not follow inverted bit 13");

  a_stack_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
    stack_fault && sup_ctl_ff.stack_fault_reset_en |=> device_reset_ff)
    else $error("stack fault did not reset");

  a_lock_frozen: assert property (@(posedge ref_clk) disable iff (!nrst)
    lock_freeze |=> $stable(pin_select_locked_ff))
    else $error("one-way lock changed after its cycle");

  a_zero_cross_on: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sup_word_ff[10] && $past(!sup_word_ff[10]) && $past(nrst)
      |-> sup_ctl_ff.zero_cross_on)
    else $error("zero-cross off while fuse forces it on");

  a_bor_always: assert property (@(posedge ref_clk) disable iff (!nrst)
    bor_mode == 2'h3 |=> sup_ctl_ff.brownout_active)
    else $error("brown-out not active in always mode");

  a_bor_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    bor_mode == 2'h0 |=> !sup_ctl_ff.brownout_active)
    else $error("brown-out active while disabled");

  a_lowv_reset_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
    low_voltage_prog_en |=> sup_ctl_ff.reset_pin_is_reset)
    else $error("reset pin not reset while low-voltage programming on");

  a_ext_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
    ext_reset_active |=> device_reset_ff)
    else $error("external reset pin ignored");

  a_words_static: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_ff == CWD_LD_DONE |=> $stable(sup_word_ff) && $stable(wdt_word_ff))
    else $error("configuration word changed after load");

  a_window_keyed: assert property (@(posedge ref_clk) disable iff (!nrst)
    wwin == 3'h2 |=> wdt_ctl_ff.window_keyed && !wdt_ctl_ff.window_sw_ctrl)
    else $error("window keyed access decode wrong");

  a_osc_fast: assert property (@(posedge ref_clk) disable iff (!nrst)
    osc_word_ff[2:0] == 3'h7 |=> osc_ctl_ff.fast_ext_clock)
    else $error("fast external clock not decoded");

endmodule : cwd_decoder

// file: tb/cwd_decoder_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the configuration word decoder
module cwd_decoder_tb_top;

  typedef struct packed {
    logic [13:0] sup;
    logic        lowv;
    logic [7:0]  exp;
  } cwd_row_t;

  logic                  ref_clk;
  logic                  nrst;
  logic [15:0]           addr;
  logic [13:0]           wdata;
  logic                  wr_stb;
  logic                  rd_stb;
  logic [13:0]           rdata_ff;
  logic [13:0]           nvm_data;
  logic [15:0]           nvm_addr_ff;
  logic                  stack_fault;
  logic                  ext_reset_pin_n;
  logic                  in_sleep;
  cwd_pkg::cwd_osc_ctl_t osc_ctl_ff;
  cwd_pkg::cwd_sup_ctl_t sup_ctl_ff;
  cwd_pkg::cwd_wdt_ctl_t wdt_ctl_ff;
  logic                  pin_select_locked_ff;
  logic                  device_reset_ff;
  logic                  config_ready_ff;
  logic [13:0]           osc_w;
  logic [13:0]           sup_w;
  logic [13:0]           wdt_w;
  logic                  lowv_w;
  int                    failures;
  int                    tests_run;

  // expected supervisor bits, msb first: debug, stack, zero-cross, brown-out, low level,
  // low-power brown-out, reset pin, power-up timer
  cwd_row_t rows [8] = '{
    '{14'h3fff, 1'h1, 8'h5a}, '{14'h001e, 1'h0, 8'ha4},
    '{14'h2dbf, 1'h0, 8'h12}, '{14'h135f, 1'h0, 8'he6},
    '{14'h3ff9, 1'h1, 8'h5b}, '{14'h3ffe, 1'h0, 8'h58},
    '{14'h3ffe, 1'h1, 8'h5a}, '{14'h3f7f, 1'h1, 8'h4a}};

  cwd_decoder dut_u (
    .ref_clk              (ref_clk),
    .nrst                 (nrst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_stb               (wr_stb),
    .rd_stb               (rd_stb),
    .rdata_ff             (rdata_ff),
    .nvm_data             (nvm_data),
    .nvm_addr_ff          (nvm_addr_ff),
    .stack_fault          (stack_fault),
    .ext_reset_pin_n      (ext_reset_pin_n),
    .in_sleep             (in_sleep),
    .osc_ctl_ff           (osc_ctl_ff),
    .sup_ctl_ff           (sup_ctl_ff),
    .wdt_ctl_ff           (wdt_ctl_ff),
    .pin_select_locked_ff (pin_select_locked_ff),
    .device_reset_ff      (device_reset_ff),
    .config_ready_ff      (config_ready_ff)
  );

  // ==========================================================
  // clock and nvm: data follows the address by one cycle
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    case (nvm_addr_ff)
      cwd_pkg::OSC_WORD_ADDR: nvm_data <= osc_w;
      cwd_pkg::SUP_WORD_ADDR: nvm_data <= sup_w;
      cwd_pkg::WDT_WORD_ADDR: nvm_data <= wdt_w;
      cwd_pkg::LOWV_WORD_ADDR: nvm_data <= {lowv_w, 13'h0};
      default:                nvm_data <= ~nvm_data;
    endcase
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [13:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [13:0] d);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata_ff;
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  // full 12-cycle reset each time so every row starts from the erased state
  task automatic load(output int cyc);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc = 0;
    while (config_ready_ff !== 1'b1 && cyc < 30000) begin
      @(posedge ref_clk);
      cyc++;
    end
  endtask : load

  function automatic cwd_pkg::cwd_osc_ctl_t exp_osc(input logic [2:0] m);
    cwd_pkg::cwd_osc_ctl_t e;
    e.osc_mode           = cwd_pkg::cwd_osc_mode_t'(m);
    e.fast_ext_clock     = (m == 3'h7);
    e.medium_ext_clock   = (m == 3'h6);
    e.slow_ext_clock     = (m == 3'h5);
    e.high_speed_crystal = (m == 3'h2);
    e.mid_crystal        = (m == 3'h1);
    e.low_power_crystal  = (m == 3'h0);
    return e;
  endfunction : exp_osc

  function automatic cwd_pkg::cwd_wdt_ctl_t exp_wdt(input logic [2:0] c, input logic [2:0] w);
    cwd_pkg::cwd_wdt_ctl_t e;
    e.clk_src = (c == 3'h7) ? cwd_pkg::CWD_WCLK_SW :
                (c >= 3'h3) ? cwd_pkg::CWD_WCLK_RSVD : cwd_pkg::cwd_wdt_clk_t'(c);
    e.window_open_8ths = (w == 3'h6) ? 3'h7 : w;
    e.window_sw_ctrl   = (w == 3'h7);
    e.window_keyed     = (w <= 3'h3);
    return e;
  endfunction : exp_wdt

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // watchdog: one 1 ms timer row plus short rows fits well inside this
  initial begin
    #2_400_000;
    failures++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    int          cyc;
    logic [13:0] d;
    logic [7:0]  m;
    nrst = 1'b0; addr = 16'h0; wdata = 14'h0; wr_stb = 1'b0; rd_stb = 1'b0;
    nvm_data = 14'h0; stack_fault = 1'b0; ext_reset_pin_n = 1'b1; in_sleep = 1'b0;
    osc_w = 14'h3fff; sup_w = 14'h3fff; wdt_w = 14'h3fff; lowv_w = 1'b1;
    failures = 0;
    tests_run = 0;
    for (int i = 0; i < 8; i++) begin
      osc_w = {11'h7ff, 3'(i)};
      wdt_w = {3'(i), 3'(7 - i), 8'hff};
      sup_w = rows[i].sup;
      lowv_w = rows[i].lowv;
      load(cyc);
      chk(16'(config_ready_ff), 16'h1);
      if (sup_w[2:1] == 2'b00) begin
        chk(16'(cyc >= 25000 && cyc < 25020), 16'h1);
      end
      m = rows[i].exp[4] ? 8'hff : 8'hf7;
      chk(16'(osc_ctl_ff), 16'(exp_osc(3'(i))));
      chk(16'(sup_ctl_ff & m), 16'(rows[i].exp & m));
      chk(16'(wdt_ctl_ff), 16'(exp_wdt(3'(i), 3'(7 - i))));
      rd(cwd_pkg::OSC_WORD_ADDR, d);
      chk(16'(d), 16'(osc_w));
      rd(cwd_pkg::SUP_WORD_ADDR, d);
      chk(16'(d), 16'(sup_w));
      rd(cwd_pkg::WDT_WORD_ADDR, d);
      chk(16'(d), 16'(wdt_w));
      @(posedge ref_clk);
      in_sleep <= 1'b1;
      settle();
      chk(16'(sup_ctl_ff.brownout_active), 16'(sup_w[7:6] == 2'b11));
      @(posedge ref_clk);
      in_sleep <= 1'b0;
      ext_reset_pin_n <= 1'b0;
      @(posedge ref_clk);
      #1 chk(16'(device_reset_ff), 16'(rows[i].exp[1]));
      @(posedge ref_clk);
      ext_reset_pin_n <= 1'b1;
      @(posedge ref_clk);
      stack_fault <= 1'b1;
      @(posedge ref_clk);
      #1 chk(16'(device_reset_ff), 16'(sup_w[12]));
      @(posedge ref_clk);
      stack_fault <= 1'b0;
      // set then clear: a one-way lock must refuse the clear
      wr(cwd_pkg::SW_CTRL_ADDR, 14'h0004);
      wr(cwd_pkg::SW_CTRL_ADDR, 14'h0000);
      settle();
      chk(16'(pin_select_locked_ff), 16'(sup_w[11]));
      rd(cwd_pkg::STATUS_ADDR, d);
      chk(16'(d), 16'({1'b1, sup_w[11], 1'b1}));
    end
    // last row left zero-cross disabled and brown-out under software control
    wr(cwd_pkg::SW_CTRL_ADDR, 14'h0003);
    settle();
    chk(16'(sup_ctl_ff.zero_cross_on), 16'h1);
    chk(16'(sup_ctl_ff.brownout_active), 16'h1);
    chk(16'(sup_ctl_ff.brownout_low_level), 16'h1);
    wr(cwd_pkg::SUP_WORD_ADDR, 14'h0000);
    rd(cwd_pkg::SUP_WORD_ADDR, d);
    chk(16'(d), 16'h3f7f);
    rd(16'h1234, d);
    chk(16'(d), 16'h0);
    @(posedge ref_clk);
    nrst <= 1'b0;
    settle();
    chk(16'(sup_ctl_ff), 16'h0);
    chk(16'(config_ready_ff), 16'h0);
    chk(nvm_addr_ff, cwd_pkg::OSC_WORD_ADDR);
    close_out();
  end

endmodule : cwd_decoder_tb_top
